// ==== core/rtc_three_timer_unit.sv ====
// three-timer realtime clock unit with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_params.svh"

// Overview of operation
// - a 24-bit periodic interval timer runs from the 32.768 kHz realtime clock.
// - the interval timer raises a recurring interrupt, with intervals up to 512 seconds.
// - a 48-bit elapsed-time counter steps once per realtime clock cycle.
// - the elapsed-time counter wraps from its maximum back to zero and keeps counting.
// - the full elapsed count is compared with a 48-bit alarm, and equality interrupts.
// - a free-running counter steps on every bus clock cycle for performance measurement.
// - software writes load the elapsed count and reads return its current value.
// - only the dedicated RTC reset pin initialises the elapsed-time counter.
// - the elapsed count shows as low, middle and high 16-bit registers, all reset to zero.
// - the alarm value sits in three read-write 16-bit registers.
// - the interval timer's current count reads through two read-only halves.
// - the bus-clock counter is read and written through a low and a high half.
// - alarm comparison begins at the second realtime clock edge after a compare write.
// - a new period takes effect only once both halves are written.
// - the interval timer counts down from the period to 1, interrupts at 1, then reloads.
// - a period of zero stops the interval timer; software programs 4 or more.
module rtc_three_timer_unit
  import rtc_timer_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rtcClk,
  input wire logic rtcResetN,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic isIdx(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
    logic [31:0] wordIdx;
    wordIdx = 32'(a >> 2);
    return (a[1:0] == 2'h0) && (wordIdx == idx);
  endfunction

  function automatic reg_id_t decode(input logic [ADDR_W-1:0] a);
    reg_id_t r;
    r = REG_NONE;
    if (isIdx(a, `IDX_ELAPSED_LOW)) r = REG_ELAPSED_LOW;
    if (isIdx(a, `IDX_ELAPSED_MID)) r = REG_ELAPSED_MID;
    if (isIdx(a, `IDX_ELAPSED_HIGH)) r = REG_ELAPSED_HIGH;
    if (isIdx(a, `IDX_ALARM_HIGH)) r = REG_ALARM_HIGH;
    if (isIdx(a, `IDX_ALARM_LOW)) r = REG_ALARM_LOW;
    if (isIdx(a, `IDX_ALARM_MID)) r = REG_ALARM_MID;
    if (isIdx(a, `IDX_PERIOD_LOW)) r = REG_PERIOD_LOW;
    if (isIdx(a, `IDX_PERIOD_HIGH)) r = REG_PERIOD_HIGH;
    if (isIdx(a, `IDX_ICOUNT_LOW)) r = REG_ICOUNT_LOW;
    if (isIdx(a, `IDX_ICOUNT_HIGH)) r = REG_ICOUNT_HIGH;
    if (isIdx(a, `IDX_BUSCNT_LOW)) r = REG_BUSCNT_LOW;
    if (isIdx(a, `IDX_BUSCNT_HIGH)) r = REG_BUSCNT_HIGH;
    if (isIdx(a, `IDX_IRQ_STATUS)) r = REG_IRQ_STATUS;
    if (isIdx(a, `IDX_IRQ_MASK)) r = REG_IRQ_MASK;
    return r;
  endfunction

  // byte lanes 0 and 1 carry the 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic rtcClkPrev_q, irq_q, awHeld_q, wHeld_q;
  logic rtcEdge, doWrite, arTake, wrElapsed, wrAlarm, intervalFire, alarmFire;
  logic [`ELAPSED_W-1:0] elapsed_q, alarm_q;
  logic [1:0] arm_q, bresp_q, rresp_q, ticksAfterCmp_q;
  logic [`INTERVAL_W-1:0] period_q, icount_q;
  logic [`HALF_W-1:0] pendLow_q;
  logic [`PERIOD_HI_W-1:0] pendHigh_q;
  period_flags_t pflags_q;
  logic [`BUSCNT_W-1:0] buscnt_q;
  irq_bits_t status_q, status_d, mask_q, setEv, clrEv;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  chan_state_t wrState_q, rdState_q;
  reg_id_t wrReg, rdReg;

  // tick = rising edge of rtcClk; rtc reset domain, so rst cannot fake a tick
  always_ff @(posedge ref_clk or negedge rtcResetN) begin
    if (!rtcResetN) begin
      rtcClkPrev_q <= 1'b0;
    end else begin
      rtcClkPrev_q <= rtcClk;
    end
  end
  assign rtcEdge = rtcClk & ~rtcClkPrev_q;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign awready = ~awHeld_q & (wrState_q == CH_IDLE);
  assign wready = ~wHeld_q & (wrState_q == CH_IDLE);
  assign doWrite = awHeld_q & wHeld_q & (wrState_q == CH_IDLE);
  assign wrReg = doWrite ? decode(awAddr_q) : REG_NONE;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      wrState_q <= CH_IDLE;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        wrState_q <= CH_RESP;
        bresp_q <= (decode(awAddr_q) == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (wrState_q == CH_RESP && bready) begin
        wrState_q <= CH_IDLE;
      end
    end
  end
  assign bvalid = (wrState_q == CH_RESP);
  assign bresp = bresp_q;

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign arready = (rdState_q == CH_IDLE);
  assign arTake = arvalid & arready;
  assign rdReg = decode(araddr);

  function automatic logic [15:0] readMux(input reg_id_t r);
    logic [15:0] v;
    v = 16'h0000;
    case (r)
      REG_ELAPSED_LOW: v = elapsed_q[15:0];
      REG_ELAPSED_MID: v = elapsed_q[31:16];
      REG_ELAPSED_HIGH: v = elapsed_q[47:32];
      REG_ALARM_LOW: v = alarm_q[15:0];
      REG_ALARM_MID: v = alarm_q[31:16];
      REG_ALARM_HIGH: v = alarm_q[47:32];
      REG_PERIOD_LOW: v = period_q[15:0];
      REG_PERIOD_HIGH: v = {8'h00, period_q[23:16]};
      REG_ICOUNT_LOW: v = icount_q[15:0];
      REG_ICOUNT_HIGH: v = {8'h00, icount_q[23:16]};
      REG_BUSCNT_LOW: v = buscnt_q[15:0];
      REG_BUSCNT_HIGH: v = buscnt_q[31:16];
      REG_IRQ_STATUS: v = {14'h0000, status_q};
      REG_IRQ_MASK: v = {14'h0000, mask_q};
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdState_q <= CH_IDLE;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (arTake) begin
      rdState_q <= CH_RESP;
      rdata_q <= {16'h0000, readMux(rdReg)};
      rresp_q <= (rdReg == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rdState_q == CH_RESP && rready) begin
      rdState_q <= CH_IDLE;
    end
  end
  assign rvalid = (rdState_q == CH_RESP);
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ****************************************************************
  // elapsed-time counter and alarm, RTC reset domain only
  // ****************************************************************
  assign wrElapsed = (wrReg == REG_ELAPSED_LOW) || (wrReg == REG_ELAPSED_MID) ||
                     (wrReg == REG_ELAPSED_HIGH);
  assign wrAlarm = (wrReg == REG_ALARM_LOW) || (wrReg == REG_ALARM_MID) ||
                   (wrReg == REG_ALARM_HIGH);

  // software write wins over a tick in the same cycle
  always_ff @(posedge ref_clk or negedge rtcResetN) begin
    if (!rtcResetN) begin
      elapsed_q <= 48'h0000_0000_0000;
    end else begin
      case (wrReg)
        REG_ELAPSED_LOW: elapsed_q[15:0] <= merge16(elapsed_q[15:0], wData_q, wStrb_q);
        REG_ELAPSED_MID: elapsed_q[31:16] <= merge16(elapsed_q[31:16], wData_q, wStrb_q);
        REG_ELAPSED_HIGH: elapsed_q[47:32] <= merge16(elapsed_q[47:32], wData_q, wStrb_q);
        default: begin
          if (rtcEdge) begin
            elapsed_q <= elapsed_q + 48'h0000_0000_0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rtcResetN) begin
    if (!rtcResetN) begin
      alarm_q <= 48'h0000_0000_0000;
    end else begin
      case (wrReg)
        REG_ALARM_LOW: alarm_q[15:0] <= merge16(alarm_q[15:0], wData_q, wStrb_q);
        REG_ALARM_MID: alarm_q[31:16] <= merge16(alarm_q[31:16], wData_q, wStrb_q);
        REG_ALARM_HIGH: alarm_q[47:32] <= merge16(alarm_q[47:32], wData_q, wStrb_q);
        default: alarm_q <= alarm_q;
      endcase
    end
  end

  // armed at reset too, so a zero alarm does not fire on the first tick
  always_ff @(posedge ref_clk or negedge rtcResetN) begin
    if (!rtcResetN) begin
      arm_q <= `ALARM_ARM_EDGES;
    end else if (wrAlarm) begin
      arm_q <= `ALARM_ARM_EDGES;
    end else if (rtcEdge && arm_q != 2'h0) begin
      arm_q <= arm_q - 2'h1;
    end
  end
  assign alarmFire = rtcEdge && !wrAlarm && (arm_q < `ALARM_ARM_EDGES) &&
                     (elapsed_q == alarm_q);

  // ****************************************************************
  // periodic interval timer
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rtcResetN) begin
    if (!rtcResetN) begin
      pendLow_q <= 16'h0000;
      pendHigh_q <= 8'h00;
      pflags_q <= '0;
      period_q <= 24'h00_0000;
    end else if (pflags_q.low && pflags_q.high) begin
      period_q <= {pendHigh_q, pendLow_q};
      pflags_q <= '0;
    end else begin
      if (wrReg == REG_PERIOD_LOW) begin
        pendLow_q <= merge16(pendLow_q, wData_q, wStrb_q);
        pflags_q.low <= 1'b1;
      end
      if (wrReg == REG_PERIOD_HIGH) begin
        pendHigh_q <= wStrb_q[0] ? wData_q[7:0] : pendHigh_q;
        pflags_q.high <= 1'b1;
      end
    end
  end

  // counts below the minimum of 4 still run; software keeps to the minimum
  always_ff @(posedge ref_clk or negedge rtcResetN) begin
    if (!rtcResetN) begin
      icount_q <= 24'h00_0000;
    end else if (rtcEdge) begin
      if (period_q == 24'h00_0000) begin
        icount_q <= 24'h00_0000;
      end else if (icount_q <= 24'h00_0001) begin
        icount_q <= period_q;
      end else begin
        icount_q <= icount_q - 24'h00_0001;
      end
    end
  end
  assign intervalFire = rtcEdge && (period_q != 24'h00_0000) &&
                        (icount_q == 24'h00_0001);

  // ****************************************************************
  // bus clock cycle counter
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buscnt_q <= 32'h0000_0000;
    end else if (wrReg == REG_BUSCNT_LOW) begin
      buscnt_q[15:0] <= merge16(buscnt_q[15:0], wData_q, wStrb_q);
    end else if (wrReg == REG_BUSCNT_HIGH) begin
      buscnt_q[31:16] <= merge16(buscnt_q[31:16], wData_q, wStrb_q);
    end else begin
      buscnt_q <= buscnt_q + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // interrupt status, mask and output
  // ****************************************************************
  assign setEv = '{alarm: alarmFire, interval: intervalFire};
  always_comb begin
    clrEv = '0;
    if (wrReg == REG_IRQ_STATUS && wStrb_q[0]) begin
      clrEv = wData_q[1:0];
    end
    if (arTake && rdReg == REG_IRQ_STATUS) begin
      clrEv = 2'h3;
    end
    // a new event beats a clear in the same cycle
    status_d = (status_q & ~clrEv) | setEv;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
      mask_q <= `IRQ_MASK_RESET;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wrReg == REG_IRQ_MASK && wStrb_q[0]) begin
        mask_q <= wData_q[1:0];
      end
      irq_q <= |(status_q & mask_q);
    end
  end
  assign irq = irq_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !rtcResetN);

  chk_elapsed_tick: assert property (
    rtcEdge && !wrElapsed |=> elapsed_q == $past(elapsed_q) + 48'h0000_0000_0001)
    else $error("elapsed counter missed a tick");
  chk_elapsed_wrap: assert property (
    rtcEdge && !wrElapsed && (&elapsed_q) |=> elapsed_q == 48'h0000_0000_0000)
    else $error("elapsed counter did not wrap to zero");
  chk_elapsed_load: assert property (
    wrReg == REG_ELAPSED_MID && wStrb_q[1:0] == 2'h3 |=> elapsed_q[31:16] == $past(wData_q[15:0]))
    else $error("elapsed middle half not loaded");
  chk_alarm_raise: assert property (
    alarmFire |=> status_q.alarm ##1 1'b1)
    else $error("alarm match did not set status");
  // ticks since the last compare write, saturating at two
  always_ff @(posedge ref_clk or negedge rtcResetN) begin
    if (!rtcResetN) begin
      ticksAfterCmp_q <= 2'h0;
    end else if (wrAlarm || (rtcEdge && ticksAfterCmp_q != 2'h2)) begin
      ticksAfterCmp_q <= wrAlarm ? 2'h0 : ticksAfterCmp_q + 2'h1;
    end
  end
  chk_alarm_wait: assert property (
    rtcEdge && ticksAfterCmp_q == 2'h0 |-> !alarmFire)
    else $error("alarm compared on first tick after write");
  chk_period_hold: assert property (
    wrReg == REG_PERIOD_LOW && !pflags_q.high && !pflags_q.low |=> $stable(period_q) [*2])
    else $error("period changed after one half only");
  chk_interval_reload: assert property (
    intervalFire |=> icount_q == $past(period_q) && status_q.interval)
    else $error("interval timer did not reload and interrupt");
  chk_interval_stop: assert property (
    period_q == 24'h00_0000 && rtcEdge |=> icount_q == 24'h00_0000 && !status_q.interval ||
    $past(status_q.interval))
    else $error("interval timer ran with zero period");
  chk_buscnt_step: assert property (
    wrReg != REG_BUSCNT_LOW && wrReg != REG_BUSCNT_HIGH |=> buscnt_q == $past(buscnt_q) + 32'h1)
    else $error("bus cycle counter did not step");
  chk_status_clear: assert property (
    wrReg == REG_IRQ_STATUS && wStrb_q[0] && wData_q[0] && !intervalFire |=> !status_q.interval)
    else $error("write one did not clear interval status");
  chk_irq_level: assert property (
    |(status_q & mask_q) |=> irq)
    else $error("unmasked status without interrupt");

  cov_interval_fire: cover property (intervalFire);
  cov_alarm_fire: cover property (alarmFire);
  cov_read_status: cover property (arTake && rdReg == REG_IRQ_STATUS && status_q != '0);
  cov_period_pair: cover property (pflags_q.low && pflags_q.high);

endmodule // rtc_three_timer_unit
`default_nettype wire

// ==== core/rtc_timer_params.svh ====
// constants of the three-timer realtime clock unit
`ifndef RTC_TIMER_PARAMS_SVH
`define RTC_TIMER_PARAMS_SVH

// ****************************************************************
// widths and timing
// ****************************************************************
`define RTC_TICK_HZ 32768
`define MAX_INTERVAL_S 512
`define ELAPSED_W 48
`define INTERVAL_W 24
`define BUSCNT_W 32
`define HALF_W 16
`define PERIOD_HI_W 8
`define MIN_PERIOD 24'h00_0004
`define ALARM_ARM_EDGES 2'h2

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define IDX_ELAPSED_LOW 32'h0B00_00C4
`define IDX_ELAPSED_MID 32'h0B00_00C6
`define IDX_ELAPSED_HIGH 32'h0B00_00C8
`define IDX_ALARM_HIGH 32'h0B00_00CA
`define IDX_ALARM_LOW 32'h0B00_00CC
`define IDX_ALARM_MID 32'h0B00_00CE
`define IDX_PERIOD_LOW 32'h0B00_00D0
`define IDX_PERIOD_HIGH 32'h0B00_00D2
`define IDX_ICOUNT_LOW 32'h0B00_00D4
`define IDX_ICOUNT_HIGH 32'h0B00_00D6
`define IDX_BUSCNT_LOW 32'h0B00_00D8
`define IDX_BUSCNT_HIGH 32'h0B00_00DA
`define IDX_IRQ_STATUS 32'h0B00_00DC
`define IDX_IRQ_MASK 32'h0B00_00DE

// ****************************************************************
// fields, reset values, bus answers
// ****************************************************************
`define IRQ_BIT_INTERVAL 0
`define IRQ_BIT_ALARM 1
`define IRQ_MASK_RESET 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== core/rtc_timer_pkg.sv ====
// types of the three-timer realtime clock unit
package rtc_timer_pkg;

  typedef enum logic [3:0] {
    REG_NONE = 4'h0,
    REG_ELAPSED_LOW = 4'h1,
    REG_ELAPSED_MID = 4'h2,
    REG_ELAPSED_HIGH = 4'h3,
    REG_ALARM_HIGH = 4'h4,
    REG_ALARM_LOW = 4'h5,
    REG_ALARM_MID = 4'h6,
    REG_PERIOD_LOW = 4'h7,
    REG_PERIOD_HIGH = 4'h8,
    REG_ICOUNT_LOW = 4'h9,
    REG_ICOUNT_HIGH = 4'hA,
    REG_BUSCNT_LOW = 4'hB,
    REG_BUSCNT_HIGH = 4'hC,
    REG_IRQ_STATUS = 4'hD,
    REG_IRQ_MASK = 4'hE
  } reg_id_t;

  typedef struct packed {
    logic alarm;
    logic interval;
  } irq_bits_t;

  typedef struct packed {
    logic high;
    logic low;
  } period_flags_t;

  typedef enum logic {
    CH_IDLE = 1'b0,
    CH_RESP = 1'b1
  } chan_state_t;

endpackage

// ==== test/testbench.sv ====
// self-checking bench for the three-timer realtime clock unit
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_params.svh"

module testbench
  import rtc_timer_pkg::*;
;
  // ****************************************************************
  // signals and register map
  // ****************************************************************
  logic refClk, rst, rtcClk, rtcResetN;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rd, arCyc, t1, c1;
  int errCount = 0;
  int numChecks = 0;
  int cyc = 0;

  localparam logic [31:0] aElL = `IDX_ELAPSED_LOW << 2;
  localparam logic [31:0] aElM = `IDX_ELAPSED_MID << 2;
  localparam logic [31:0] aElH = `IDX_ELAPSED_HIGH << 2;
  localparam logic [31:0] aAlH = `IDX_ALARM_HIGH << 2;
  localparam logic [31:0] aAlL = `IDX_ALARM_LOW << 2;
  localparam logic [31:0] aAlM = `IDX_ALARM_MID << 2;
  localparam logic [31:0] aPerL = `IDX_PERIOD_LOW << 2;
  localparam logic [31:0] aPerH = `IDX_PERIOD_HIGH << 2;
  localparam logic [31:0] aCntL = `IDX_ICOUNT_LOW << 2;
  localparam logic [31:0] aCntH = `IDX_ICOUNT_HIGH << 2;
  localparam logic [31:0] aBusL = `IDX_BUSCNT_LOW << 2;
  localparam logic [31:0] aBusH = `IDX_BUSCNT_HIGH << 2;
  localparam logic [31:0] aSts = `IDX_IRQ_STATUS << 2;
  localparam logic [31:0] aMsk = `IDX_IRQ_MASK << 2;
  localparam logic [31:0] aBad = 32'h2C00_0380;
  localparam logic [31:0] zeroRegs [0:11] = '{aElL, aElM, aElH, aAlH, aAlL, aAlM,
    aPerL, aPerH, aCntL, aCntH, aSts, aMsk};
  localparam logic [31:0] elRegs [0:2] = '{aElL, aElM, aElH};

  rtc_three_timer_unit uut (
    .ref_clk(refClk),
    .rst(rst),
    .rtcClk(rtcClk),
    .rtcResetN(rtcResetN),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .irq(irq)
  );

  initial begin
    refClk = 1'b0;
    forever #25 refClk = ~refClk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic endSim();
    if (errCount == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge refClk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errCount++;
      endSim();
    end
  end

  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t response %h expected %h", $time, got, exp);
    end
  endtask

  // readies are sampled mid-cycle: inputs only move at rising edges, so
  // the mid-cycle value is the one the next edge sees, with no race
  task automatic busWrite(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s,
                          input logic [1:0] er);
    logic awHit, wHit, awDone, wDone, hit;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(negedge refClk);
      awHit = awvalid && awready;
      wHit = wvalid && wready;
      @(posedge refClk);
      if (awHit) begin
        awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (wHit) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    do begin
      @(negedge refClk);
      hit = bvalid;
      rsp = bresp;
      @(posedge refClk);
    end while (!hit);
    bready <= 1'b0;
    // idle edge, so a following call never drives bready twice in one step
    @(posedge refClk);
    chkResp(rsp, er);
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    busWrite(a, d, 4'h3, `RESP_OKAY);
  endtask

  task automatic busRead(input logic [31:0] a);
    logic hit;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge refClk);
      hit = arready;
      arCyc = cyc;
      @(posedge refClk);
    end while (!hit);
    arvalid <= 1'b0;
    do begin
      @(negedge refClk);
      hit = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge refClk);
    end while (!hit);
    rready <= 1'b0;
    @(posedge refClk);
  endtask

  task automatic readChk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    busRead(a);
    chkData(rd, exp);
    chkResp(rsp, er);
  endtask

  task automatic irqChk(input logic exp);
    @(negedge refClk);
    chkData({31'h0, irq}, {31'h0, exp});
    @(posedge refClk);
  endtask

  // the bench owns every tick, so counter values are known exactly
  task automatic tick(input int n);
    repeat (n) begin
      rtcClk <= 1'b1;
      repeat (2) @(posedge refClk);
      rtcClk <= 1'b0;
      repeat (4) @(posedge refClk);
    end
  endtask

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    rtcResetN = 1'b0;
    rtcClk = 1'b0;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 32'h0000_0000;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (2) @(posedge refClk);
    rst <= 1'b0;
    rtcResetN <= 1'b1;
    @(posedge refClk);
    for (int i = 0; i < 12; i++) begin
      readChk(zeroRegs[i], 32'h0000_0000, `RESP_OKAY);
    end
    readChk(aBad, 32'h0000_0000, `RESP_SLVERR);
    busWrite(aBad, 16'h5A5A, 4'h3, `RESP_SLVERR);
    wr(aCntL, 16'h00AA);
    readChk(aCntL, 32'h0000_0000, `RESP_OKAY);
    // interval timer: one half alone must not load the period
    wr(aPerL, 16'h0004);
    tick(1);
    readChk(aCntL, 32'h0000_0000, `RESP_OKAY);
    wr(aPerH, 16'h0000);
    tick(1);
    readChk(aCntL, 32'h0000_0004, `RESP_OKAY);
    tick(3);
    readChk(aCntL, 32'h0000_0001, `RESP_OKAY);
    tick(1);
    irqChk(1'b0);
    wr(aMsk, 16'h0001);
    irqChk(1'b1);
    readChk(aCntL, 32'h0000_0004, `RESP_OKAY);
    wr(aSts, 16'h0001);
    irqChk(1'b0);
    readChk(aSts, 32'h0000_0000, `RESP_OKAY);
    wr(aPerL, 16'h0000);
    wr(aPerH, 16'h0000);
    tick(1);
    readChk(aCntL, 32'h0000_0000, `RESP_OKAY);
    // elapsed counter: load all ones, then wrap
    for (int i = 0; i < 3; i++) begin
      wr(elRegs[i], 16'hFFFF);
    end
    for (int i = 0; i < 3; i++) begin
      readChk(elRegs[i], 32'h0000_FFFF, `RESP_OKAY);
    end
    tick(1);
    for (int i = 0; i < 3; i++) begin
      readChk(elRegs[i], 32'h0000_0000, `RESP_OKAY);
    end
    tick(3);
    readChk(aElL, 32'h0000_0003, `RESP_OKAY);
    rst <= 1'b1;
    repeat (2) @(posedge refClk);
    rst <= 1'b0;
    @(posedge refClk);
    readChk(aElL, 32'h0000_0003, `RESP_OKAY);
    // alarm: first tick after a compare write is ignored, the second compares
    wr(aMsk, 16'h0002);
    wr(aElL, 16'h0010);
    wr(aAlL, 16'h0010);
    tick(1);
    irqChk(1'b0);
    wr(aAlL, 16'h0012);
    tick(1);
    irqChk(1'b0);
    tick(1);
    irqChk(1'b1);
    readChk(aSts, 32'h0000_0002, `RESP_OKAY);
    readChk(aSts, 32'h0000_0000, `RESP_OKAY);
    irqChk(1'b0);
    // bus-clock counter
    wr(aBusL, 16'h0000);
    wr(aBusH, 16'h1234);
    readChk(aBusH, 32'h0000_1234, `RESP_OKAY);
    busRead(aBusL);
    t1 = rd;
    c1 = arCyc;
    busRead(aBusL);
    chkData(rd - t1, arCyc - c1);
    // longest period: upper byte lanes of the high half are dropped
    busWrite(aPerH, 16'hFFFF, 4'hF, `RESP_OKAY);
    wr(aPerL, 16'hFFFF);
    readChk(aPerH, 32'h0000_00FF, `RESP_OKAY);
    tick(1);
    readChk(aCntL, 32'h0000_FFFF, `RESP_OKAY);
    readChk(aCntH, 32'h0000_00FF, `RESP_OKAY);
    rtcResetN <= 1'b0;
    repeat (2) @(posedge refClk);
    rtcResetN <= 1'b1;
    @(posedge refClk);
    readChk(aElL, 32'h0000_0000, `RESP_OKAY);
    endSim();
  end
endmodule  // testbench
`default_nettype wire
